// [verif/out_update_tb_top.sv]
// self-checking bench for the output update block
`timescale 1ns/1ps
module out_update_tb_top;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  range_jumper = 4'h0;
  logic        req_enable = 1'b0;
  logic [1:0]  req_channel = 2'h0;
  logic [15:0] req_data = 16'h0000;
  logic [31:0] output_points;
  logic [63:0] channel_code;
  logic [3:0]  channel_range_10v;
  logic        outputs_enabled;
  logic [15:0] exp_code [4];
  logic [15:0] seed = 16'h3131;
  int          error_cnt = 0;
  int          check_count = 0;
  always #50 core_clk = ~core_clk;
  plc_host_model host (.core_clk(core_clk), .req_enable(req_enable),
    .req_channel(req_channel), .req_data(req_data), .output_points(output_points));
  out_update dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .output_points(output_points), .range_jumper(range_jumper),
    .channel_code(channel_code), .channel_range_10v(channel_range_10v),
    .outputs_enabled(outputs_enabled));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [63:0] codes();
    return {exp_code[3], exp_code[2], exp_code[1], exp_code[0]};
  endfunction : codes
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // hold one point block for five scans; expectation follows enable
  task automatic send(input logic en, input logic [1:0] ch, input logic [15:0] d);
    @(negedge core_clk);
    req_enable = en;
    req_channel = ch;
    req_data = d;
    if (en) exp_code[ch] = d;
    else exp_code = '{default: 16'h0000};
    repeat (5) @(negedge core_clk);
  endtask : send
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    exp_code = '{default: 16'h0000};
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    check("range", 64'h0, 64'(channel_range_10v));
    check("code", 64'h0, channel_code);
    send(1'b1, 2'h3, 16'hFFFF);
    check("code", codes(), channel_code);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      range_jumper = seed[3:0];
      send(1'b1, seed[5:4], (i == 5) ? 16'h0000 : lfsr(seed));
      check("code", codes(), channel_code);
      check("range", 64'(range_jumper), 64'(channel_range_10v));
      check("enable", 64'h1, 64'(outputs_enabled));
    end
    send(1'b0, 2'h1, 16'h5A5A);
    check("code", 64'h0, channel_code);
    check("enable", 64'h0, 64'(outputs_enabled));
    send(1'b1, 2'h2, 16'h1234);
    check("code", codes(), channel_code);
    clk_en = 1'b0;
    req_channel = 2'h0;
    req_data = 16'hBEEF;
    repeat (5) @(negedge core_clk);
    check("code", codes(), channel_code);
    clk_en = 1'b1;
    send(1'b1, 2'h0, 16'hBEEF);
    check("code", codes(), channel_code);
    close_out();
  end
endmodule : out_update_tb_top

// [verif/plc_host_model.sv]
// host controller model driving the module's output point block
`timescale 1ns/1ps
module plc_host_model (
  input  wire logic        core_clk,
  input  wire logic        req_enable,
  input  wire logic [1:0]  req_channel,
  input  wire logic [15:0] req_data,
  output logic      [31:0] output_points
);
  logic [12:0] spare = 13'h0000;
  // unused points keep changing so nothing leans on them
  always @(negedge core_clk) spare <= ~spare ^ {spare[11:0], 1'b1};
  assign output_points = {req_enable, spare, req_channel, req_data};
endmodule : plc_host_model

// [verilog/out_update.sv]
// output point decode, per-channel data store and enable gating
`timescale 1ns/1ps
`include "out_update_cfg.svh"

module out_update
  import out_update_pkg::*;
#(
  parameter int CHANNELS = `CHANNEL_COUNT,
  parameter int WIDTH    = `WORD_WIDTH
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire logic [`POINT_COUNT-1:0]    output_points,
  input  wire logic [CHANNELS-1:0]        range_jumper,
  output logic      [CHANNELS*WIDTH-1:0]  channel_code,
  output logic      [CHANNELS-1:0]        channel_range_10v,
  output logic                            outputs_enabled
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers (points and jumpers come from outside the domain)
  logic [`POINT_COUNT-1:0] points_meta;
  logic [`POINT_COUNT-1:0] points_sync;
  logic [CHANNELS-1:0]     range_meta;
  logic [CHANNELS-1:0]     range_sync;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      points_meta <= '0;
      points_sync <= '0;
      range_meta  <= `RANGE_RESET;
      range_sync  <= `RANGE_RESET;
    end else if (clk_en) begin
      points_meta <= output_points;
      points_sync <= points_meta;
      range_meta  <= range_jumper;
      range_sync  <= range_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of the two interface words
  point_block_type  block_word;
  wire logic [WIDTH-1:0] data_word;
  wire logic [1:0]       channel_index;
  wire logic             enable_bit;

  assign block_word    = point_block_type'(points_sync);
  assign data_word     = block_word.data;
  assign channel_index = {block_word.control.channel_select_high,
                          block_word.control.channel_select_low};
  assign enable_bit    = block_word.control.enable;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel storage
  logic [WIDTH-1:0] stored [CHANNELS];
  logic             next_enabled;
  assign next_enabled = enable_bit;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      wire logic hit = (channel_index == 2'(ch));
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          stored[ch] <= `DATA_RESET;
        end else if (clk_en) begin
          if (!enable_bit) begin
            stored[ch] <= `DATA_RESET;
          end else if (hit) begin
            stored[ch] <= data_word;
          end
        end
      end
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          channel_code[ch*WIDTH +: WIDTH] <= `DATA_RESET;
        end else if (clk_en) begin
          channel_code[ch*WIDTH +: WIDTH] <= enable_bit && hit ? data_word :
                                             (enable_bit ? stored[ch] : `DATA_RESET);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // range and enable status
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_range_10v <= `RANGE_RESET;
      outputs_enabled   <= 1'b0;
    end else if (clk_en) begin
      channel_range_10v <= range_sync;
      outputs_enabled   <= next_enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_disable_zeroes: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit |=> channel_code == '0)
    else $error("outputs not zero while disabled");

  a_disable_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit |=> stored[0] == '0 && stored[3] == '0)
    else $error("store not cleared on disable");

  a_select_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h0 |=> stored[0] == $past(data_word))
    else $error("channel one not latched");

  a_select_ch3: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h3 |=> channel_code[63:48] == $past(data_word))
    else $error("channel four not updated");

  a_others_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h1 |=> stored[1] == $past(stored[1]))
    else $error("unselected channel changed");

  a_rise_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit ##1 clk_en && enable_bit && channel_index != 2'h2
      |=> channel_code[47:32] == '0)
    else $error("channel not zero after enable rise");

  a_range_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en |=> channel_range_10v == $past(range_sync))
    else $error("range not following setting");

  a_enable_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en ##1 clk_en |-> ##1 outputs_enabled == $past(points_sync[31]))
    else $error("enable flag wrong");

  ////////////////////////////////////////////////////////////////////////////
  // per-channel checks
  // channel two latch
  a_latch_ch1: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h1 |=> stored[1] == $past(data_word))
    else $error("channel two not latched");

  a_latch_ch2: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h2 |=> stored[2] == $past(data_word))
    else $error("channel three not latched");

  a_latch_ch3: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h3 |=> stored[3] == $past(data_word))
    else $error("channel four not latched");

  a_code_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h0 |=> channel_code[15:0] == $past(data_word))
    else $error("channel one not updated");

  a_code_ch1: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h1 |=> channel_code[31:16] == $past(data_word))
    else $error("channel two not updated");

  a_code_ch2: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h2 |=> channel_code[47:32] == $past(data_word))
    else $error("channel three not updated");

  a_hold_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h0 |=> stored[0] == $past(stored[0]))
    else $error("channel one store changed");

  a_hold_ch2: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h2 |=> stored[2] == $past(stored[2]))
    else $error("channel three store changed");

  a_hold_ch3: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h3 |=> stored[3] == $past(stored[3]))
    else $error("channel four store changed");

  a_code_hold_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h0 |=> channel_code[15:0] == $past(stored[0]))
    else $error("channel one output not held");

  a_code_hold_ch1: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h1 |=> channel_code[31:16] == $past(stored[1]))
    else $error("channel two output not held");

  a_code_hold_ch2: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h2 |=> channel_code[47:32] == $past(stored[2]))
    else $error("channel three output not held");

  a_code_hold_ch3: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index != 2'h3 |=> channel_code[63:48] == $past(stored[3]))
    else $error("channel four output not held");

  a_clear_mid: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit |=> stored[1] == '0 && stored[2] == '0)
    else $error("middle stores not cleared");

  a_disabled_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit |=> !outputs_enabled)
    else $error("enable flag high while disabled");

  a_enabled_high: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit |=> outputs_enabled)
    else $error("enable flag low while enabled");

  a_rise_zero_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit ##1 clk_en && enable_bit && channel_index != 2'h0
      |=> channel_code[15:0] == '0)
    else $error("channel one not zero after enable rise");

  a_rise_zero_ch1: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit ##1 clk_en && enable_bit && channel_index != 2'h1
      |=> channel_code[31:16] == '0)
    else $error("channel two not zero after enable rise");

  a_rise_zero_ch3: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit ##1 clk_en && enable_bit && channel_index != 2'h3
      |=> channel_code[63:48] == '0)
    else $error("channel four not zero after enable rise");

  a_rise_store_ch1: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && !enable_bit ##1 clk_en && enable_bit && channel_index != 2'h1
      |=> stored[1] == '0)
    else $error("channel two store not clear after enable rise");

  a_zero_write_ch2: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h2 && data_word == '0
      |=> channel_code[47:32] == '0)
    else $error("channel three not zero after zero write");

  a_full_scale_ch0: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en && enable_bit && channel_index == 2'h0 && data_word == 16'hFFFF
      |=> channel_code[15:0] == 16'hFFFF)
    else $error("channel one full scale lost");

  // frozen outputs while clock enable low
  a_freeze_code: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clk_en |=> channel_code == $past(channel_code))
    else $error("outputs moved while clock enable low");

  // frozen stores while clock enable low
  a_freeze_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clk_en |=> stored[0] == $past(stored[0]) && stored[3] == $past(stored[3]))
    else $error("stores moved while clock enable low");

  // frozen status while clock enable low
  a_freeze_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clk_en |=> outputs_enabled == $past(outputs_enabled))
    else $error("status moved while clock enable low");

  // frozen synchronisers while clock enable low
  a_freeze_sync: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clk_en |=> points_sync == $past(points_sync) && range_sync == $past(range_sync))
    else $error("synchronisers moved while clock enable low");

  a_meta_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en |=> points_meta == $past(output_points))
    else $error("first point stage wrong");

  a_sync_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en |=> points_sync == $past(points_meta))
    else $error("second point stage wrong");

  a_range_sync: assert property (@(posedge core_clk) disable iff (!rst_b)
    clk_en |=> range_sync == $past(range_meta))
    else $error("range stage wrong");

endmodule : out_update

// [verilog/out_update_cfg.svh]
// constants for the four-channel output update block
`ifndef OUT_UPDATE_CFG_SVH
`define OUT_UPDATE_CFG_SVH
`define POINT_COUNT      32
`define WORD_WIDTH       16
`define SEL_LSB          0
`define SEL_MSB          1
`define ENABLE_BIT       15
`define CHANNEL_COUNT    4
`define DATA_RESET       16'h0000
`define RANGE_RESET      4'h0
`endif

// [verilog/out_update_pkg.sv]
// types for the four-channel output update block
package out_update_pkg;
  typedef enum logic {range_5v_type_v, range_10v_type_v} range_type;
  typedef struct packed {
    logic        enable;
    logic [12:0] unused;
    logic        channel_select_high;
    logic        channel_select_low;
  } control_word_type;
  typedef struct packed {
    control_word_type  control;
    logic [15:0]       data;
  } point_block_type;
endpackage : out_update_pkg
